//--- dv/status_word_sva.sv
`timescale 1ns/1ps
`include "status_word_defines.vh"
module status_word_sva (
    input wire clk_i,
    input wire rst_b_i,
    input wire op_valid_i,
    input wire [3:0] op_i,
    input wire [3:0] cmd_i,
    input wire irq_entry_i,
    input wire instr_done_i,
    input wire [15:0] psw_o,
    input wire save_strobe_o,
    input wire step_trap_o,
    input wire [7:0] trap_vector_o,
    input wire irq_enabled_o,
    input wire step_down_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    a_fixed_bits: assert property ((psw_o & 16'h702a) == 16'h7002)
        else $error("fixed bits wrong");
    a_irq_entry: assert property (irq_entry_i |=> psw_o[9:8] == 2'h0 && save_strobe_o)
        else $error("irq entry wrong");
    a_irq_enable: assert property (cmd_i == `CMD_ENABLE_IRQ && !irq_entry_i |=> psw_o[9])
        else $error("enable lost");
    a_irq_mask: assert property (cmd_i == `CMD_MASK_IRQ |=> !psw_o[9] && !irq_enabled_o)
        else $error("mask lost");
    a_dir_cmd: assert property (cmd_i == `CMD_SET_DIR || cmd_i == `CMD_CLR_DIR |=>
        step_down_o == psw_o[10] && psw_o[10] == ($past(cmd_i) == `CMD_SET_DIR))
        else $error("direction wrong");
    a_carry_flip: assert property (cmd_i == `CMD_NOT_CARRY |=> psw_o[0] != $past(psw_o[0]))
        else $error("carry not inverted");
    a_logic_clear: assert property (op_valid_i && op_i == `OP_LOGIC && cmd_i == `CMD_NONE
        |=> !psw_o[0] && !psw_o[11]) else $error("logic flags wrong");
    a_inc_carry: assert property (op_valid_i && op_i == `OP_INC && cmd_i == `CMD_NONE
        |=> $stable(psw_o[0])) else $error("inc changed carry");
    a_step_trap: assert property (instr_done_i && psw_o[8] |=>
        step_trap_o && trap_vector_o == `TRAP_VECTOR) else $error("no step trap");
    a_step_restore: assert property ($rose(psw_o[8]) |-> $past(cmd_i) == `CMD_LOAD_WORD)
        else $error("step set without restore");
    a_no_trap: assert property (!psw_o[8] |=> !step_trap_o)
        else $error("trap without single step");
    a_strobe_pulse: assert property (!irq_entry_i |=> !save_strobe_o)
        else $error("save strobe without entry");
    cover property (op_valid_i && op_i == `OP_MUL);
    cover property (irq_entry_i ##1 save_strobe_o);
    cover property (step_trap_o);
    cover property (cmd_i == `CMD_LOAD_BYTE);
endmodule // status_word_sva

//--- dv/status_word_tb.sv
`timescale 1ns/1ps
bind status_word status_word_sva u_sva (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .op_valid_i(op_valid_i),
    .op_i(op_i),
    .cmd_i(cmd_i),
    .irq_entry_i(irq_entry_i),
    .instr_done_i(instr_done_i),
    .psw_o(psw_o),
    .save_strobe_o(save_strobe_o),
    .step_trap_o(step_trap_o),
    .trap_vector_o(trap_vector_o),
    .irq_enabled_o(irq_enabled_o),
    .step_down_o(step_down_o)
);
module status_word_tb;
    reg clk_i = 1'h0, rst_b_i = 1'h0, op_valid_i = 1'h0, word_i = 1'h0, mul_signed_i = 1'h0;
    reg mul_imm_i = 1'h0, shift_carry_i = 1'h0, shift_uses_carry_i = 1'h0;
    reg irq_entry_i = 1'h0, instr_done_i = 1'h0;
    reg [3:0] op_i = 4'h0, cmd_i = 4'h0;
    reg [15:0] a_i = 16'h0, b_i = 16'h0, res_i = 16'h0, mul_hi_i = 16'h0, load_data_i = 16'h0;
    wire [15:0] psw_o, saved_image_o;
    wire [7:0] trap_vector_o;
    wire save_strobe_o, step_trap_o, irq_enabled_o, step_down_o;
    integer mismatches = 0, checked = 0, cycles = 0;
    status_word DUT (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .op_valid_i(op_valid_i),
        .op_i(op_i),
        .word_i(word_i),
        .a_i(a_i),
        .b_i(b_i),
        .res_i(res_i),
        .mul_hi_i(mul_hi_i),
        .mul_signed_i(mul_signed_i),
        .mul_imm_i(mul_imm_i),
        .shift_carry_i(shift_carry_i),
        .shift_uses_carry_i(shift_uses_carry_i),
        .cmd_i(cmd_i),
        .load_data_i(load_data_i),
        .irq_entry_i(irq_entry_i),
        .instr_done_i(instr_done_i),
        .psw_o(psw_o),
        .saved_image_o(saved_image_o),
        .save_strobe_o(save_strobe_o),
        .step_trap_o(step_trap_o),
        .trap_vector_o(trap_vector_o),
        .irq_enabled_o(irq_enabled_o),
        .step_down_o(step_down_o)
    );
    always #5 clk_i = ~clk_i;
    task complete_run;
        begin
            $display("mismatches %0d checked %0d", mismatches, checked);
            if (mismatches == 0 && checked > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            mismatches = mismatches + 1;
            complete_run;
        end
    end
    task chk(input [15:0] g, input [15:0] e);
        begin
            checked = checked + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("unexpected at %0t: got %h exp %h", $time, g, e);
            end
        end
    endtask
    // k = {op, cmd, irq, done, signed or carry in, uses carry, 2'b0, imm, word}; d = {a, b, res, hi}
    task st(input [15:0] k, input [63:0] d, input [31:0] mv);
        begin
            @(posedge clk_i);
            {op_i, cmd_i, irq_entry_i, instr_done_i, mul_signed_i, shift_uses_carry_i} <= k[15:4];
            op_valid_i <= k[15:12] != 4'h0;
            word_i <= k[0];
            mul_imm_i <= k[1];
            shift_carry_i <= k[5];
            {a_i, b_i, res_i, mul_hi_i} <= d;
            load_data_i <= d[15:0];
            @(posedge clk_i);
            {op_valid_i, cmd_i, irq_entry_i, instr_done_i} <= 7'h00;
            #1 chk(psw_o & mv[31:16], mv[15:0]);
        end
    endtask
    task t_arith;
        begin
            st(16'h1000, 64'h00ff000100000000, 32'hffff7057);
            st(16'h3000, 64'h0000000100010000, 32'hffff7003);
            st(16'h2000, 64'h0000000100ff0000, 32'hffff7097);
            st(16'h1001, 64'h7fff000180000000, 32'hffff7896);
            st(16'h0100, 64'h0, 32'hffff7897);
            st(16'h5000, 64'h0, 32'hffff7056);
        end
    endtask
    task t_mul_shift;
        begin
            st(16'h6001, 64'h0000000000000001, 32'hffff7857);
            st(16'h7000, 64'h0, 32'hffff7057);
            st(16'h6003, 64'h000000008000ffff, 32'hffff7056);
            st(16'h6003, 64'h0000000080000000, 32'hffff7857);
            st(16'h6021, 64'h000000008000ffff, 32'hffff7056);
            st(16'h6020, 64'h00000000ff800000, 32'hffff7056);
            st(16'h8030, 64'h0000000000400000, 32'hffff7813);
            st(16'h9010, 64'h0000000000400000, 32'hffff7812);
            st(16'ha010, 64'h0, 32'hffff7856);
        end
    endtask
    task t_ctrl;
        begin
            st(16'h0300, 64'h0, 32'hffff7857);
            st(16'h0400, 64'h0, 32'hffff7a57);
            st(16'h0600, 64'h0, 32'hffff7e57);
            chk({14'h0, irq_enabled_o, step_down_o}, 16'h0003);
            st(16'h0700, 64'h0, 32'hffff7a57);
            st(16'h0500, 64'h0, 32'hffff7857);
            st(16'h0200, 64'h0, 32'hffff7856);
        end
    endtask
    task t_load_irq;
        begin
            st(16'h0800, 64'h000000000000ffff, 32'hffff78d7);
            st(16'h0900, 64'h000000000000ffff, 32'hffffffd7);
            st(16'h0040, 64'h0, 32'hffffffd7);
            chk({7'h00, step_trap_o, trap_vector_o}, 16'h0101);
            st(16'h0080, 64'h0, 32'hfffffcd7);
            chk(saved_image_o, 16'hffd7);
            chk({15'h0, save_strobe_o}, 16'h0001);
        end
    endtask
    task t_reset;
        begin
            @(posedge clk_i);
            rst_b_i <= 1'h0;
            repeat (2) @(posedge clk_i);
            #1 chk(psw_o & 16'h7fff, 16'h7002);
            @(posedge clk_i);
            rst_b_i <= 1'h1;
            st(16'h0400, 64'h0, 32'h7fff7202);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'h1;
        #1 chk(psw_o, 16'h7002);
        t_arith;
        t_mul_shift;
        t_ctrl;
        t_load_irq;
        t_reset;
        complete_run;
    end
endmodule // status_word_tb

//--- logic/result_flag_unit.v
`timescale 1ns/1ps
`include "status_word_defines.vh"
module result_flag_unit (
    input wire [3:0] op_i,
    input wire word_i,
    input wire [15:0] a_i,
    input wire [15:0] b_i,
    input wire [15:0] res_i,
    input wire [15:0] mul_hi_i,
    input wire mul_signed_i,
    input wire mul_imm_i,
    input wire shift_carry_i,
    input wire shift_uses_carry_i,
    input wire [15:0] flags_i,
    output reg [15:0] flags_o
);
    reg [16:0] sum;
    reg c_top;
    reg c_next;
    reg half;
    reg [15:0] ext;
    reg big;
    reg msb;
    reg msb_next;
    always @* begin
        flags_o = flags_i;
        sum = (op_i == `OP_SUB || op_i == `OP_DEC) ? {1'b0, a_i} - {1'b0, b_i}
            : {1'b0, a_i} + {1'b0, b_i};
        half = a_i[4] ^ b_i[4] ^ res_i[4];
        msb = word_i ? res_i[15] : res_i[7];
        msb_next = word_i ? res_i[14] : res_i[6];
        if (word_i) begin
            c_top = sum[16];
            c_next = a_i[15] ^ b_i[15] ^ res_i[15];
        end else begin
            c_top = a_i[8] ^ b_i[8] ^ sum[8];
            c_next = a_i[7] ^ b_i[7] ^ res_i[7];
        end
        ext = word_i ? {16{res_i[15]}} : {8'h00, {8{res_i[7]}}};
        if (mul_imm_i)
            big = (mul_hi_i != {16{res_i[15]}});
        else if (word_i)
            big = mul_signed_i ? (mul_hi_i != ext) : (mul_hi_i != 16'h0000);
        else
            big = mul_signed_i ? (res_i[15:8] != ext[7:0]) : (res_i[15:8] != 8'h00);
        case (op_i)
            `OP_ADD, `OP_SUB, `OP_INC, `OP_DEC, `OP_LOGIC, `OP_SHL1, `OP_SHR1, `OP_SHIFTN: begin
                flags_o[`BIT_PARITY] = ~^res_i[7:0];
                flags_o[`BIT_ZERO] = word_i ? (res_i == 16'h0000)
                    : (res_i[7:0] == 8'h00);
                flags_o[`BIT_SIGN] = msb;
            end
            default: begin
            end
        endcase
        case (op_i)
            `OP_ADD, `OP_SUB, `OP_INC, `OP_DEC: begin
                flags_o[`BIT_HALF] = half;
                flags_o[`BIT_OVF] = c_top ^ c_next;
                if (op_i == `OP_ADD || op_i == `OP_SUB)
                    flags_o[`BIT_CARRY] = c_top;
            end
            `OP_LOGIC: begin
                flags_o[`BIT_CARRY] = 1'b0;
                flags_o[`BIT_OVF] = 1'b0;
            end
            `OP_MUL: begin
                flags_o[`BIT_CARRY] = big;
                flags_o[`BIT_OVF] = big;
            end
            `OP_DIV: begin
                flags_o[`BIT_OVF] = 1'b0;
            end
            `OP_SHL1: begin
                if (shift_uses_carry_i)
                    flags_o[`BIT_CARRY] = shift_carry_i;
                flags_o[`BIT_OVF] = shift_carry_i ^ msb;
            end
            `OP_SHR1: begin
                if (shift_uses_carry_i)
                    flags_o[`BIT_CARRY] = shift_carry_i;
                flags_o[`BIT_OVF] = msb ^ msb_next;
            end
            `OP_SHIFTN: begin
                if (shift_uses_carry_i)
                    flags_o[`BIT_CARRY] = shift_carry_i;
            end
            default: begin
            end
        endcase
    end
endmodule // result_flag_unit

//--- logic/status_word.v
`timescale 1ns/1ps
`include "status_word_defines.vh"
module status_word (
    input wire clk_i,
    input wire rst_b_i,
    input wire op_valid_i,
    input wire [3:0] op_i,
    input wire word_i,
    input wire [15:0] a_i,
    input wire [15:0] b_i,
    input wire [15:0] res_i,
    input wire [15:0] mul_hi_i,
    input wire mul_signed_i,
    input wire mul_imm_i,
    input wire shift_carry_i,
    input wire shift_uses_carry_i,
    input wire [3:0] cmd_i,
    input wire [15:0] load_data_i,
    input wire irq_entry_i,
    input wire instr_done_i,
    output reg [15:0] psw_o,
    output reg [15:0] saved_image_o,
    output reg save_strobe_o,
    output reg step_trap_o,
    output reg [7:0] trap_vector_o,
    output reg irq_enabled_o,
    output reg step_down_o
);
    reg [15:0] flags_reg;
    reg [15:0] flags_next;
    wire [15:0] alu_flags;
    // legacy bit is sticky, so the image is built from flags_kept, which ORs the stored bit 15 into flags_next
    wire [15:0] flags_kept = {flags_next[15] | flags_reg[15], flags_next[14:0]};
    result_flag_unit u_flags (
        .op_i(op_i),
        .word_i(word_i),
        .a_i(a_i),
        .b_i(b_i),
        .res_i(res_i),
        .mul_hi_i(mul_hi_i),
        .mul_signed_i(mul_signed_i),
        .mul_imm_i(mul_imm_i),
        .shift_carry_i(shift_carry_i),
        .shift_uses_carry_i(shift_uses_carry_i),
        .flags_i(flags_reg),
        .flags_o(alu_flags)
    );
    function [15:0] image;
        input [15:0] f;
        begin
            image = (f & `PSW_LIVE_MASK) | `PSW_ONES_MASK;
        end
    endfunction
    always @* begin
        flags_next = flags_reg;
        if (op_valid_i)
            flags_next = alu_flags;
        case (cmd_i)
            `CMD_SET_CARRY: flags_next[`BIT_CARRY] = 1'b1;
            `CMD_CLR_CARRY: flags_next[`BIT_CARRY] = 1'b0;
            `CMD_NOT_CARRY: flags_next[`BIT_CARRY] = ~flags_reg[`BIT_CARRY];
            `CMD_ENABLE_IRQ: flags_next[`BIT_IE] = 1'b1;
            `CMD_MASK_IRQ: flags_next[`BIT_IE] = 1'b0;
            `CMD_SET_DIR: flags_next[`BIT_DIR] = 1'b1;
            `CMD_CLR_DIR: flags_next[`BIT_DIR] = 1'b0;
            `CMD_LOAD_BYTE: flags_next[7:0] = load_data_i[7:0];
            `CMD_LOAD_WORD: flags_next = load_data_i;
            default: begin
            end
        endcase
        if (irq_entry_i) begin
            flags_next[`BIT_IE] = 1'b0;
            flags_next[`BIT_STEP] = 1'b0;
        end
        flags_next = flags_next & `PSW_LIVE_MASK;
    end
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_reg <= 16'h0000;
            psw_o <= `PSW_ONES_MASK;
            saved_image_o <= `PSW_ONES_MASK;
            save_strobe_o <= 1'b0;
            step_trap_o <= 1'b0;
            trap_vector_o <= 8'h00;
            irq_enabled_o <= 1'b0;
            step_down_o <= 1'b0;
        end else begin
            flags_reg <= flags_kept;
            psw_o <= image(flags_kept);
            save_strobe_o <= irq_entry_i;
            if (irq_entry_i)
                saved_image_o <= image(flags_reg);
            step_trap_o <= instr_done_i & flags_reg[`BIT_STEP];
            trap_vector_o <= `TRAP_VECTOR;
            irq_enabled_o <= flags_next[`BIT_IE];
            step_down_o <= flags_next[`BIT_DIR];
        end
    end
endmodule // status_word

//--- logic/status_word_defines.vh
// How it works
// - each flag-affecting operation updates the six result flags from its result; the code updates all six only for add and subtract.
// - dedicated instructions set, clear or invert carry; control flags change only by instruction.
// - interrupt entry clears interrupt enable and single step.
// - reset clears every flag except the legacy mode bit; the code clears the legacy mode bit too.
// - fixed 16-bit layout; bits 1,12-14 read one, 3,5 read zero.
// - byte access touches low 8 bits only, excluding overflow; word touches all.
// - whole word saved on interrupt or call, restored on returns and pop; the code saves only on irq_entry_i.
// - add/subtract carry from bit 7 or 15; increment/decrement keep carry.
// - logical operations clear carry and overflow.
// - multiply sets carry and overflow when upper half is not zero or sign extension.
// - shifts through carry load carry with the bit moved in.
// - parity set when low result byte has even count of ones.
// - half carry set on carry or borrow across the low nibble.
// - zero set when all byte or word result bits are zero.
// - sign copies result bit 7 or bit 15.
// - add/subtract overflow when carries out of top two bits differ.
// - one-bit shift overflow from carry versus top bit, or top two bits.
// - single step raises vector 1 trap after each instruction.
// - single step becomes set only by restoring a saved image.
// - enable instruction sets interrupt enable, mask instruction clears it.
// - direction flag set/cleared by bit instructions; set means step down.
// - legacy mode bit has no functional effect.
`ifndef STATUS_WORD_DEFINES_VH
`define STATUS_WORD_DEFINES_VH
`define BIT_CARRY 0
`define BIT_PARITY 2
`define BIT_HALF 4
`define BIT_ZERO 6
`define BIT_SIGN 7
`define BIT_STEP 8
`define BIT_IE 9
`define BIT_DIR 10
`define BIT_OVF 11
`define BIT_LEGACY 15
`define PSW_ONES_MASK 16'h7002
`define PSW_LIVE_MASK 16'h8fd5
`define TRAP_VECTOR 8'h01
// operation classes
`define OP_NONE 4'h0
`define OP_ADD 4'h1
`define OP_SUB 4'h2
`define OP_INC 4'h3
`define OP_DEC 4'h4
`define OP_LOGIC 4'h5
`define OP_MUL 4'h6
`define OP_DIV 4'h7
`define OP_SHL1 4'h8
`define OP_SHR1 4'h9
`define OP_SHIFTN 4'ha
// control commands
`define CMD_NONE 4'h0
`define CMD_SET_CARRY 4'h1
`define CMD_CLR_CARRY 4'h2
`define CMD_NOT_CARRY 4'h3
`define CMD_ENABLE_IRQ 4'h4
`define CMD_MASK_IRQ 4'h5
`define CMD_SET_DIR 4'h6
`define CMD_CLR_DIR 4'h7
`define CMD_LOAD_BYTE 4'h8
`define CMD_LOAD_WORD 4'h9
`endif
